// File: logic/ccr_regs.v
// Purpose: card configuration register bank in attribute space, with mode and task file decode
// Assumes: host socket pins asynchronous to clk (20 MHz); core logic on clk
// Notes:   writes take effect on the synchronised falling edge of the write strobe
//
// Overview of operation
// - soft reset bit resets card, bit kept
// - hard reset clears configuration, restarts initialisation
// - style bit: zero pulse, one level interrupts
// - mapping zero: memory mode, 0-f, 400-7ff
// - mapping one: sixteen contiguous I/O addresses
// - mapping two: primary I/O addresses decoded
// - mapping three: secondary I/O addresses decoded
// - any reset forces mapping field to zero
// - change flag mirrors ready-change latch
// - status pin low: change, enable, I/O mode
// - power-down bit selects sleep or active
// - raw ready busy until power state reached
// - auto sleep when idle, wake on command
// - pending bit follows internal interrupt request
// - pending bit zero while interrupts disabled
// - pin register resets 0c, fixed ones
// - latch set on raw change, host writable
// - raw read gives ready level, write masks
// - copy number bit held as written
// - registers reached only with register-select low
// - registers usable outside true ide only
`timescale 1ns/1ps
`include "ccr_defines.vh"
module ccr_regs (
  // clock and reset
  input  wire        clk,
  input  wire        rst_b,
  input  wire        clk_en,
  // host socket pins
  input  wire        reg_sel_b,
  input  wire        ce1_b,
  input  wire        ce2_b,
  input  wire        oe_b,
  input  wire        we_b,
  input  wire        iord_b,
  input  wire        iowr_b,
  input  wire        hard_reset,
  input  wire [10:0] addr,
  input  wire [7:0]  data_in,
  output reg  [7:0]  data_out,
  output wire        data_oe,
  output reg         status_change_pin_b,
  output reg         ready_pin,
  // core side
  input  wire        true_ide_mode,
  input  wire        core_irq_request,
  input  wire        irq_disable_bit,
  input  wire        core_ready,
  input  wire        core_idle,
  input  wire        command_received,
  input  wire        power_state_reached,
  output wire        card_reset,
  output wire        irq_level_mode,
  output wire        eight_bit_io_only,
  output reg         card_sleep,
  output wire        copy_number,
  output reg         task_file_sel,
  output reg  [3:0]  task_file_index
);

  localparam SYNC_W = 27;

  // synchronised pin vector
  wire [SYNC_W-1:0] pins_s;

  // register state
  reg               we_prev_q;
  reg               soft_reset_request_q;
  reg               irq_style_select_q;
  reg  [5:0]        map_select_q;
  reg               status_change_enable_q;
  reg               eight_bit_io_q;
  reg               power_down_request_q;
  reg               pwr_busy_q;
  reg               ready_change_latch_q;
  reg               ready_mask_q;
  reg               raw_ready_prev_q;
  reg               copy_number_q;
  reg  [7:0]        rd_mux;

  wire              tf_hit;
  wire [3:0]        tf_idx;

  ccr_sync #(
    .WIDTH   (SYNC_W),
    .RST_VAL ({7'h7f, 1'b0, 11'h000, 8'h00})
  ) u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .pin_in   ({reg_sel_b, ce1_b, ce2_b, oe_b, we_b, iord_b, iowr_b, hard_reset, addr, data_in}),
    .sync_out (pins_s)
  );

  // strobes reset inactive, so no false access follows reset
  wire              reg_sel_s_b  = pins_s[26];
  wire              ce1_s_b      = pins_s[25];
  wire              ce2_s_b      = pins_s[24];
  wire              oe_s_b       = pins_s[23];
  wire              we_s_b       = pins_s[22];
  wire              iord_s_b     = pins_s[21];
  wire              iowr_s_b     = pins_s[20];
  wire              hard_reset_s = pins_s[19];
  wire [10:0]       addr_s       = pins_s[18:8];
  wire [7:0]        din_s        = pins_s[7:0];

  // task file decode per mapping mode; returns {hit, index}
  function [4:0] tf_decode;
    input [5:0]  map;
    input [10:0] a;
    input        mem_cycle;
    input        io_cycle;
    begin
      tf_decode = 5'h00;
      case (map)
        `CCR_MAP_MEMORY:
        begin
          if (mem_cycle && (a[10:4] == 7'h00 || a[10]))
            tf_decode = {1'b1, a[3:0]};
        end
        `CCR_MAP_CONTIG:
        begin
          if (io_cycle)
            tf_decode = {1'b1, a[3:0]};
        end
        `CCR_MAP_PRIMARY:
        begin
          if (io_cycle && a[9:3] == 7'h3e)
            tf_decode = {2'b10, a[2:0]};
          else if (io_cycle && a[9:1] == 9'h1fb)
            tf_decode = {4'hf, a[0]};
        end
        `CCR_MAP_SECONDARY:
        begin
          if (io_cycle && a[9:3] == 7'h2e)
            tf_decode = {2'b10, a[2:0]};
          else if (io_cycle && a[9:1] == 9'h1bb)
            tf_decode = {4'hf, a[0]};
        end
        default:
          tf_decode = 5'h00;
      endcase
    end
  endfunction

  // hard reset clears the configuration fields and the soft reset bit; soft reset clears the fields but not its own bit
  wire   cfg_clear = hard_reset_s | soft_reset_request_q;
  assign card_reset = cfg_clear;
  wire   io_mode   = (map_select_q != `CCR_MAP_MEMORY);
  wire   card_sel  = ~ce1_s_b | ~ce2_s_b;

  // attribute access: register-select low, no I/O strobe, even byte lane, not true ide
  wire   attr_ok = ~reg_sel_s_b & ~ce1_s_b & iord_s_b & iowr_s_b & ~addr_s[0] & ~true_ide_mode;
  wire   wr_stb  = attr_ok & ~we_s_b & we_prev_q;
  wire   rd_act  = attr_ok & ~oe_s_b;
  assign data_oe = rd_act;

  // status derivations
  wire   raw_ready_state = core_ready & ~pwr_busy_q;
  wire   change_flag     = ready_change_latch_q;
  wire   irq_pending     = core_irq_request & ~irq_disable_bit;
  wire   set_latch       = (raw_ready_state != raw_ready_prev_q) & ~ready_mask_q;

  assign irq_level_mode    = irq_style_select_q;
  assign eight_bit_io_only = eight_bit_io_q;
  assign copy_number       = copy_number_q;

  // soft reset bit survives its own reset; hard reset or a host write of zero clears it
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      soft_reset_request_q <= 1'b0;
      we_prev_q            <= 1'b1;
    end
    else if (clk_en)
    begin
      we_prev_q <= we_s_b;
      if (hard_reset_s)
        soft_reset_request_q <= 1'b0;
      else if (wr_stb && addr_s == `CCR_OFS_OPTION)
        soft_reset_request_q <= din_s[`CCR_OPT_SOFT_RESET_REQUEST];
    end
  end

  // configuration fields cleared by every reset
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_style_select_q     <= 1'b0;
      map_select_q           <= `CCR_MAP_MEMORY;
      status_change_enable_q <= 1'b0;
      eight_bit_io_q         <= 1'b0;
      power_down_request_q   <= 1'b0;
      ready_mask_q           <= 1'b0;
      copy_number_q          <= 1'b0;
    end
    else if (clk_en)
    begin
      if (cfg_clear)
      begin
        irq_style_select_q     <= 1'b0;
        map_select_q           <= `CCR_MAP_MEMORY;
        status_change_enable_q <= 1'b0;
        eight_bit_io_q         <= 1'b0;
        power_down_request_q   <= 1'b0;
        ready_mask_q           <= 1'b0;
        copy_number_q          <= 1'b0;
      end
      else if (wr_stb)
      begin
        case (addr_s)
          `CCR_OFS_OPTION:
          begin
            irq_style_select_q <= din_s[`CCR_OPT_STYLE];
            map_select_q       <= din_s[`CCR_OPT_IDX_HI:`CCR_OPT_IDX_LO];
          end
          `CCR_OFS_STATUS:
          begin
            status_change_enable_q <= din_s[`CCR_STS_SIGEN];
            eight_bit_io_q         <= din_s[`CCR_STS_IO8];
            power_down_request_q   <= din_s[`CCR_STS_PWD];
          end
          `CCR_OFS_PINREP:
            ready_mask_q <= din_s[`CCR_PIN_RAW];
          `CCR_OFS_COPY:
            copy_number_q <= din_s[`CCR_CPY_NUM];
          default:
            copy_number_q <= copy_number_q;
        endcase
      end
    end
  end

  // ready-change latch: a hardware set wins over a host write of zero
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ready_change_latch_q <= 1'b0;
      raw_ready_prev_q     <= 1'b0;
    end
    else if (clk_en)
    begin
      raw_ready_prev_q <= raw_ready_state;
      if (set_latch)
        ready_change_latch_q <= 1'b1;
      else if (cfg_clear)
        ready_change_latch_q <= 1'b0;
      else if (wr_stb && addr_s == `CCR_OFS_PINREP)
        ready_change_latch_q <= din_s[`CCR_PIN_LATCH];
    end
  end

  // power state: busy from a request change until the core confirms the state
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pwr_busy_q <= 1'b0;
      card_sleep <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_stb && addr_s == `CCR_OFS_STATUS && !cfg_clear &&
          din_s[`CCR_STS_PWD] != power_down_request_q)
        pwr_busy_q <= 1'b1;
      else if (power_state_reached)
        pwr_busy_q <= 1'b0;
      // a command wakes the card, but a host power-down request keeps it asleep
      if (power_down_request_q)
        card_sleep <= 1'b1;
      else if (command_received)
        card_sleep <= 1'b0;
      else if (core_idle)
        card_sleep <= 1'b1;
      else
        card_sleep <= 1'b0;
    end
  end

  // read mux; fixed bits come from constants so writes cannot reach them
  always @*
  begin
    rd_mux = 8'h00;
    case (addr_s)
      `CCR_OFS_OPTION:
        rd_mux = {soft_reset_request_q, irq_style_select_q, map_select_q};
      `CCR_OFS_STATUS:
        rd_mux = {change_flag, status_change_enable_q, eight_bit_io_q, 2'b00,
                  power_down_request_q, irq_pending, 1'b0};
      `CCR_OFS_PINREP:
        rd_mux = `CCR_PIN_FIXED_ONES | {2'b00, ready_change_latch_q, 3'b000,
                  raw_ready_state, 1'b0};
      `CCR_OFS_COPY:
        rd_mux = {3'b000, copy_number_q, 4'h0};
      default:
        rd_mux = 8'h00;
    endcase
  end

  assign {tf_hit, tf_idx} = tf_decode(map_select_q, addr_s,
                                      reg_sel_s_b & (~oe_s_b | ~we_s_b) & card_sel,
                                      ~reg_sel_s_b & (~iord_s_b | ~iowr_s_b) & card_sel);

  // registered outputs toward host and core
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      data_out            <= 8'h00;
      status_change_pin_b <= 1'b1;
      ready_pin           <= 1'b0;
      task_file_sel       <= 1'b0;
      task_file_index     <= 4'h0;
    end
    else if (clk_en)
    begin
      data_out            <= rd_act ? rd_mux : 8'h00;
      status_change_pin_b <= ~(change_flag & status_change_enable_q & io_mode);
      ready_pin           <= raw_ready_state;
      task_file_sel       <= tf_hit & ~cfg_clear;
      task_file_index     <= tf_idx;
    end
  end

endmodule

// File: logic/ccr_defines.vh
// Purpose: shared offsets, field positions and reset values of the card configuration registers
// Assumes: attribute space byte addresses on an 11-bit address bus
// Notes:   definitions only
`ifndef CCR_DEFINES_VH
`define CCR_DEFINES_VH

// attribute-space offsets
`define CCR_OFS_OPTION      11'h200
`define CCR_OFS_STATUS      11'h202
`define CCR_OFS_PINREP      11'h204
`define CCR_OFS_COPY        11'h206

// reset values
`define CCR_RST_OPTION      8'h00
`define CCR_RST_STATUS      8'h00
`define CCR_RST_PINREP      8'h0c
`define CCR_RST_COPY        8'h00

// option register fields
`define CCR_OPT_SOFT_RESET_REQUEST      7
`define CCR_OPT_STYLE       6
`define CCR_OPT_IDX_HI      5
`define CCR_OPT_IDX_LO      0

// status register fields
`define CCR_STS_CHANGE      7
`define CCR_STS_SIGEN       6
`define CCR_STS_IO8         5
`define CCR_STS_PWD         2
`define CCR_STS_IRQ         1

// pin replacement fields
`define CCR_PIN_LATCH       5
`define CCR_PIN_RAW         1
`define CCR_PIN_FIXED_ONES  8'h0c

// copy register field
`define CCR_CPY_NUM         4

// mapping select codes
`define CCR_MAP_MEMORY      6'h00
`define CCR_MAP_CONTIG      6'h01
`define CCR_MAP_PRIMARY     6'h02
`define CCR_MAP_SECONDARY   6'h03

`endif

// File: logic/ccr_sync.v
// Purpose: three-stage synchroniser for pin inputs
// Assumes: pins are asynchronous to clk
// Notes:   a bit changes only once the second and third stages agree
`timescale 1ns/1ps
module ccr_sync #(
  parameter WIDTH             = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_b,
  input  wire             clk_en,
  // data
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  integer         i;

  // s1 is read only by s2; agreement filter rejects a one-cycle disagreement
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_q     <= RST_VAL;
      s2_q     <= RST_VAL;
      s3_q     <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else if (clk_en)
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < WIDTH; i = i + 1)
        if (s2_q[i] == s3_q[i])
          sync_out[i] <= s3_q[i];
    end
  end

endmodule

// File: dv/ccr_regs_properties.sv
// Purpose: port-level assertions for the card configuration registers
// Assumes: one clock domain, top ports only
// Notes:   pins cross a three-stage synchroniser, so windows allow a few clocks
`timescale 1ns/1ps
module ccr_regs_properties (
  // clock and reset
  input wire       clk,
  input wire       rst_b,
  input wire       clk_en,
  // host pins
  input wire       reg_sel_b,
  input wire       oe_b,
  input wire       hard_reset,
  // core side
  input wire       true_ide_mode,
  input wire       core_ready,
  input wire       core_idle,
  input wire       command_received,
  // card outputs
  input wire [7:0] data_out,
  input wire       data_oe,
  input wire       status_change_pin_b,
  input wire       ready_pin,
  input wire       card_reset,
  input wire       card_sleep,
  input wire       task_file_sel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // reset paths
  chk_hard_reset_hit: assert property ($rose(hard_reset) |-> ##[1:6] card_reset)
    else $error("hard reset pin did not reset the card");
  chk_tf_quiet: assert property (card_reset [*2] |-> !task_file_sel)
    else $error("task file hit during card reset");
  chk_pin_in_reset: assert property (card_reset |-> ##[0:2] status_change_pin_b)
    else $error("status change pin low while card in reset");
  // ready and power
  chk_ready_low: assert property (!core_ready [*3] |-> !ready_pin)
    else $error("ready pin high while core busy");
  chk_auto_sleep: assert property (clk_en && core_idle && !command_received && !card_reset |=> card_sleep)
    else $error("idle card did not sleep");
  // read gating, stale data would collide on a shared bus
  chk_regsel_gate: assert property (reg_sel_b [*6] |-> !data_oe)
    else $error("card drives data without register select");
  chk_ide_gate: assert property (true_ide_mode [*2] |-> !data_oe)
    else $error("card drives data in true ide mode");
  chk_read_only: assert property (oe_b [*6] |-> !data_oe)
    else $error("card drives data without read strobe");
  chk_data_quiet: assert property (!data_oe [*2] |-> data_out == 8'h00)
    else $error("read data not cleared after read");
endmodule

bind ccr_regs ccr_regs_properties u_chk (.*);

// File: dv/ccr_host.sv
// Purpose: host socket model for attribute and task file cycles
// Assumes: pins change at the falling clock edge only
// Notes:   writes have no handshake, so six-clock phases cover the sync delay
`timescale 1ns/1ps
module ccr_host (
  // clock
  input  wire        clk,
  // socket pins
  output reg         reg_sel_b,
  output reg         ce1_b,
  output reg         oe_b,
  output reg         we_b,
  output reg         iord_b,
  output reg  [10:0] addr,
  output reg  [7:0]  data_in,
  // card answers
  input  wire [7:0]  data_out,
  input  wire        data_oe,
  input  wire        task_file_sel,
  input  wire [3:0]  task_file_index
);
  // socket idle at time zero
  initial
  begin
    reg_sel_b = 1'b1;
    ce1_b = 1'b1;
    oe_b = 1'b1;
    we_b = 1'b1;
    iord_b = 1'b1;
    addr = 11'h000;
    data_in = 8'h5a;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // address and enables settle before any strobe
  task automatic sel(input [10:0] a, input rs);
    addr = a;
    reg_sel_b = rs;
    ce1_b = 1'b0;
    idle(6);
  endtask

  // freed data lines show the inverse, never the old byte
  task automatic desel;
    idle(6);
    ce1_b = 1'b1;
    reg_sel_b = 1'b1;
    data_in = ~data_in;
    idle(2);
  endtask

  task automatic wr(input [10:0] a, input [7:0] d, input rs);
    data_in = d;
    sel(a, rs);
    we_b = 1'b0;
    idle(6);
    we_b = 1'b1;
    desel;
  endtask

  // bounded wait for the card to drive, byte taken a clock later
  task automatic rd(input [10:0] a, output [7:0] d, output oe);
    sel(a, 1'b0);
    oe_b = 1'b0;
    oe = 1'b0;
    d = 8'h00;
    repeat (8)
      if (!oe)
      begin
        @(negedge clk);
        oe = (data_oe === 1'b1);
      end
    if (oe)
    begin
      @(negedge clk);
      d = data_out;
    end
    oe_b = 1'b1;
    desel;
  endtask

  // task file read, memory or io strobe
  task automatic tf(input io, input [10:0] a, output h, output [3:0] x);
    sel(a, !io);
    if (io)
      iord_b = 1'b0;
    else
      oe_b = 1'b0;
    h = 1'b0;
    x = 4'h0;
    repeat (8)
      if (!h)
      begin
        @(negedge clk);
        h = (task_file_sel === 1'b1);
        x = h ? task_file_index : 4'h0;
      end
    iord_b = 1'b1;
    oe_b = 1'b1;
    desel;
  endtask
endmodule

// File: dv/ccr_regs_bench.sv
// Purpose: self-checking bench for the card configuration registers
// Assumes: host model on the socket pins, core side driven here
// Notes:   one task per scenario, each judges its own results
`timescale 1ns/1ps
`include "ccr_defines.vh"
module ccr_regs_bench;
  // clock, reset and core side
  reg         clk;
  reg         rst_b;
  reg         hard_reset;
  reg         true_ide_mode;
  reg         core_irq_request;
  reg         irq_disable_bit;
  reg         core_ready;
  reg         core_idle;
  reg         command_received;
  reg         power_state_reached;
  // socket and card outputs
  wire        reg_sel_b, ce1_b, oe_b, we_b, iord_b, data_oe, status_change_pin_b, ready_pin;
  wire        card_reset, irq_level_mode, eight_bit_io_only, card_sleep, copy_number, task_file_sel;
  wire [10:0] addr;
  wire [7:0]  data_in, data_out;
  wire [3:0]  task_file_index;
  int         failures = 0;
  int         check_count = 0;

  ccr_regs u_dut (.clk_en(1'b1), .ce2_b(1'b1), .iowr_b(1'b1), .*);
  ccr_host u_host (.*);

  // 20 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task cmp(input [8:0] g, input [8:0] e);
    check_count = check_count + 1;
    if (g !== e)
    begin
      failures = failures + 1;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task w(input [10:0] a, input [7:0] d);
    u_host.wr(a, d, 1'b0);
  endtask

  task rr(input [10:0] a, input [7:0] e);
    reg [7:0] d;
    reg       oe;
    u_host.rd(a, d, oe);
    cmp({oe, d}, {1'b1, e});
  endtask

  // one-clock pulse: command when c, else power state reached
  task pulse(input c);
    @(negedge clk);
    command_received = c;
    power_state_reached = !c;
    @(negedge clk);
    command_received = 1'b0;
    power_state_reached = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task t_reset;
    rr(`CCR_OFS_OPTION, `CCR_RST_OPTION);
    rr(`CCR_OFS_STATUS, `CCR_RST_STATUS);
    rr(`CCR_OFS_PINREP, `CCR_RST_PINREP);
    rr(`CCR_OFS_COPY, `CCR_RST_COPY);
    $display("t_reset done");
  endtask

  task t_status;
    w(`CCR_OFS_COPY, 8'hff);
    rr(`CCR_OFS_COPY, 8'h10);
    cmp(copy_number, 1'b1);
    w(`CCR_OFS_STATUS, 8'hfb);
    cmp(eight_bit_io_only, 1'b1);
    w(`CCR_OFS_PINREP, 8'h20);
    rr(`CCR_OFS_PINREP, 8'h2c);
    rr(`CCR_OFS_STATUS, 8'he0);
    cmp(status_change_pin_b, 1'b1);
    w(`CCR_OFS_OPTION, 8'h01);
    cmp(status_change_pin_b, 1'b0);
    w(`CCR_OFS_STATUS, 8'h20);
    cmp(status_change_pin_b, 1'b1);
    w(`CCR_OFS_PINREP, 8'h00);
    w(`CCR_OFS_OPTION, 8'h00);
    $display("t_status done");
  endtask

  task t_irq;
    core_irq_request = 1'b1;
    rr(`CCR_OFS_STATUS, 8'h22);
    irq_disable_bit = 1'b1;
    rr(`CCR_OFS_STATUS, 8'h20);
    core_irq_request = 1'b0;
    irq_disable_bit = 1'b0;
    $display("t_irq done");
  endtask

  // table digits: map, io, addr(3), hit, index
  task t_map;
    reg [27:0] tb [0:7];
    reg        h;
    reg [3:0]  x;
    tb = '{28'h0040515, 28'h0000c1c, 28'h1103a1a, 28'h211f313,
           28'h213f71f, 28'h3117616, 28'h313761e, 28'h2117000};
    for (int i = 0; i < 8; i++)
    begin
      w(`CCR_OFS_OPTION, {4'h0, tb[i][27:24]});
      u_host.tf(tb[i][20], tb[i][18:8], h, x);
      cmp({3'h0, h, x}, {3'h0, tb[i][4:0]});
    end
    $display("t_map done");
  endtask

  task t_style;
    w(`CCR_OFS_OPTION, 8'h40);
    cmp(irq_level_mode, 1'b1);
    w(`CCR_OFS_OPTION, 8'h00);
    cmp(irq_level_mode, 1'b0);
    $display("t_style done");
  endtask

  task t_pwd;
    core_ready = 1'b1;
    repeat (4) @(negedge clk);
    w(`CCR_OFS_PINREP, 8'h00);
    rr(`CCR_OFS_PINREP, 8'h0e);
    w(`CCR_OFS_STATUS, 8'h04);
    cmp(card_sleep, 1'b1);
    cmp(ready_pin, 1'b0);
    pulse(1'b0);
    cmp(ready_pin, 1'b1);
    rr(`CCR_OFS_PINREP, 8'h2e);
    w(`CCR_OFS_PINREP, 8'h02);
    w(`CCR_OFS_STATUS, 8'h00);
    cmp(card_sleep, 1'b0);
    rr(`CCR_OFS_PINREP, 8'h0c);
    pulse(1'b0);
    core_idle = 1'b1;
    repeat (3) @(negedge clk);
    cmp(card_sleep, 1'b1);
    command_received = 1'b1;
    @(negedge clk);
    cmp(card_sleep, 1'b0);
    command_received = 1'b0;
    core_idle = 1'b0;
    pulse(1'b1);
    cmp(card_sleep, 1'b0);
    $display("t_pwd done");
  endtask

  task t_refuse;
    reg [7:0] d;
    reg       oe;
    u_host.wr(`CCR_OFS_COPY, 8'h00, 1'b1);
    true_ide_mode = 1'b1;
    u_host.wr(`CCR_OFS_COPY, 8'h00, 1'b0);
    u_host.rd(`CCR_OFS_COPY, d, oe);
    cmp(oe, 1'b0);
    true_ide_mode = 1'b0;
    u_host.rd(`CCR_OFS_COPY + 11'h001, d, oe);
    cmp(oe, 1'b0);
    rr(`CCR_OFS_COPY, 8'h10);
    $display("t_refuse done");
  endtask

  task t_soft_reset_request;
    w(`CCR_OFS_OPTION, 8'h83);
    cmp(card_reset, 1'b1);
    rr(`CCR_OFS_OPTION, 8'h80);
    hard_reset = 1'b1;
    repeat (8) @(negedge clk);
    hard_reset = 1'b0;
    repeat (8) @(negedge clk);
    cmp(card_reset, 1'b0);
    rr(`CCR_OFS_OPTION, 8'h00);
    rr(`CCR_OFS_COPY, 8'h00);
    $display("t_soft_reset_request done");
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // reset for five clocks, then the scenarios in order
  initial
  begin
    rst_b = 1'b0;
    hard_reset = 1'b0;
    true_ide_mode = 1'b0;
    core_irq_request = 1'b0;
    irq_disable_bit = 1'b0;
    core_ready = 1'b0;
    core_idle = 1'b0;
    command_received = 1'b0;
    power_state_reached = 1'b0;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    t_reset;
    t_status;
    t_irq;
    t_map;
    t_style;
    t_pwd;
    t_refuse;
    t_soft_reset_request;
    complete_run;
  end

  // watchdog: the scenarios need about 1000 clocks
  initial
  begin
    repeat (20000) @(posedge clk);
    failures = failures + 1;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run;
  end
endmodule
